// *** rtl/plo_ctrl.v ***
/*
 * Link option control bank of a 10/100 PHY: two control registers on APB
 * and the option logic they steer (start delimiter, duplex, LED, isolation,
 * odd-nibble transmit, far-end drop, RMII sample clock select).
 * Assumes PCLK is REF_CLK; TX_CLK, TX_EN, TX_ER and status/strap pins come
 * from outside this clock and are synchronised here; receive symbol strobes
 * come from PCS logic on REF_CLK.
 * Registers sit in the low half of the 32-bit word; the upper half reads zero.
 */
// Summary of operation
// - two-bit select picks 80/50/35, 120/75/50, 240/150/100 timers whether or not fast enabled
// - early mode raises receive valid on the /J/ symbol alone
// - early mode flags receive error when /K/ does not follow /J/
// - normal mode raises receive valid only after /J/ then /K/
// - far-end drop turns transmitter off on link loss, 100 Mbps only
// - fiber bit loaded from strap at reset, writable, selects 100BASE-FX
// - fast parallel-detect bit selects shortened parallel-detect link-up time
// - fast parallel-detect bit set automatically by fast or robust crossover mode
// - extended full duplex forces full duplex against forced 100BASE-TX partner when local is 100BASE-TX
// - without extended full duplex, duplex follows standard parallel detection
// - qualified LED lights only for 100BASE-TX full duplex links
// - qualified LED shows link only, no activity blinking
// - isolation blanks MII outputs on 100TX half duplex or any 10 Mbps link
// - idle error detect bit enables receive errors during idle
// - odd-nibble control one disables odd-nibble transmit error detection
// - odd-nibble end stretches transmit enable one cycle with transmit error
// - RMII receive data sampled on receive clock pin or crystal reference
`timescale 1ns/10ps
`default_nettype none
`include "plo_map.vh"

module plo_ctrl (
    input  wire        REF_CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        FIBER_STRAP,
    input  wire        RMII_MODE,
    input  wire        LINK_UP,
    input  wire        SPEED_100,
    input  wire        LOCAL_100TX,
    input  wire        PARTNER_FORCED_100TX,
    input  wire        PD_FULL_DUPLEX,
    input  wire        ACTIVITY,
    input  wire        RX_SYM_STB,
    input  wire        RX_SYM_J,
    input  wire        RX_SYM_K,
    input  wire        RX_SYM_END,
    input  wire        RX_SYM_ERR,
    input  wire        TX_CLK,
    input  wire        TX_EN,
    input  wire        TX_ER,
    output reg         FAST_AN_ACTIVE,
    output reg  [7:0]  AN_BREAK_MS,
    output reg  [7:0]  AN_INHIBIT_MS,
    output reg  [7:0]  AN_WAIT_MS,
    output reg         RX_DV,
    output reg         RX_ER,
    output reg         TX_EN_PCS,
    output reg         TX_ER_PCS,
    output reg         TX_DISABLE,
    output reg         FIBER_MODE,
    output reg         FAST_PD_LINKUP,
    output reg         FULL_DUPLEX,
    output reg         LED_LINK,
    output reg         MII_ISOLATE,
    output reg         RX_SAMPLE_ON_RXCLK
);

    localparam RX_IDLE = 2'h0;
    localparam RX_GOTJ = 2'h1;
    localparam RX_DATA = 2'h2;

    // synchronisers for pins and the transmit clock domain
    reg  [9:0]  sync1_r;
    reg  [9:0]  sync2_r;
    wire [9:0]  pins;
    assign pins = {TX_ER, TX_EN, TX_CLK, ACTIVITY, PD_FULL_DUPLEX,
                   PARTNER_FORCED_100TX, LOCAL_100TX, SPEED_100, LINK_UP,
                   FIBER_STRAP};

    wire strap_s   = sync2_r[0];
    wire link_s    = sync2_r[1];
    wire spd100_s  = sync2_r[2];
    wire local_s   = sync2_r[3];
    wire partner_s = sync2_r[4];
    wire pdfull_s  = sync2_r[5];
    wire act_s     = sync2_r[6];
    wire txclk_s   = sync2_r[7];
    wire txen_s    = sync2_r[8];
    wire txer_s    = sync2_r[9];

    // no reset on the chain: the strap must already be settled when reset ends
    always @(posedge REF_CLK) begin
        sync1_r <= pins;
        sync2_r <= sync1_r;
    end

    reg  [15:0] ctrl_one_r;
    reg  [15:0] ctrl_two_r;
    reg  [15:0] ctrl_two_nxt;
    reg         strap_done_r;

    // a write lands on the completing edge, when ready is already high
    wire wr_fire  = PSEL & PENABLE & PREADY & PWRITE;
    wire hit_one  = (PADDR == `PLO_ADDR_CTRL_ONE);
    wire hit_two  = (PADDR == `PLO_ADDR_CTRL_TWO);

    wire fast_mdix   = ctrl_one_r[`PLO_C1_FAST_MDIX];
    wire robust_mdix = ctrl_one_r[`PLO_C1_ROBUST_MDIX];

    // crossover modes keep fast parallel detect set; a write of zero loses
    always @* begin
        ctrl_two_nxt = ctrl_two_r;
        if (wr_fire && hit_two) begin
            ctrl_two_nxt = PWDATA[15:0];
        end
        if (fast_mdix || robust_mdix) begin
            ctrl_two_nxt[`PLO_C2_FAST_PD] = 1'b1;
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_one_r   <= `PLO_RST_CTRL_ONE;
            ctrl_two_r   <= `PLO_RST_CTRL_TWO;
            strap_done_r <= 1'b0;
        end else begin
            // reserved bits of phy_control_one never store, so reads return zero
            if (wr_fire && hit_one) begin
                ctrl_one_r <= PWDATA[15:0] & `PLO_MASK_CTRL_ONE;
            end
            ctrl_two_r <= ctrl_two_nxt;
            // strap sampled on the first edge after release, once synchronised
            if (!strap_done_r) begin
                strap_done_r                  <= 1'b1;
                ctrl_two_r[`PLO_C2_FIBER_EN]  <= strap_s;
            end
        end
    end

    // APB slave: one wait state, PREADY registered
    // read data is captured on the first access edge and holds until the next access, read or write
    always @(posedge REF_CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY  <= 1'b1;
            PSLVERR <= !(hit_one || hit_two);
            if (hit_one) begin
                PRDATA <= {16'h0000, ctrl_one_r};
            end else if (hit_two) begin
                PRDATA <= {16'h0000, ctrl_two_r};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // negotiation timers; code 11 has no timers and leaves fast mode off
    // timers follow the select even while fast mode is off, so enabling needs no settling
    wire [1:0] an_sel = ctrl_one_r[`PLO_C1_FAST_AN_SEL_HI:`PLO_C1_FAST_AN_SEL_LO];
    wire       an_en  = ctrl_one_r[`PLO_C1_FAST_AN_EN];

    always @(posedge REF_CLK) begin
        if (RESET) begin
            FAST_AN_ACTIVE <= 1'b0;
            AN_BREAK_MS    <= 8'h00;
            AN_INHIBIT_MS  <= 8'h00;
            AN_WAIT_MS     <= 8'h00;
        end else begin
            FAST_AN_ACTIVE <= an_en && (an_sel != 2'h3);
            if (an_sel == `PLO_AN_SEL_00) begin
                AN_BREAK_MS   <= `PLO_T00_BREAK;
                AN_INHIBIT_MS <= `PLO_T00_INHIBIT;
                AN_WAIT_MS    <= `PLO_T00_WAIT;
            end else if (an_sel == `PLO_AN_SEL_01) begin
                AN_BREAK_MS   <= `PLO_T01_BREAK;
                AN_INHIBIT_MS <= `PLO_T01_INHIBIT;
                AN_WAIT_MS    <= `PLO_T01_WAIT;
            end else if (an_sel == `PLO_AN_SEL_10) begin
                AN_BREAK_MS   <= `PLO_T10_BREAK;
                AN_INHIBIT_MS <= `PLO_T10_INHIBIT;
                AN_WAIT_MS    <= `PLO_T10_WAIT;
            end else begin
                AN_BREAK_MS   <= 8'h00;
                AN_INHIBIT_MS <= 8'h00;
                AN_WAIT_MS    <= 8'h00;
            end
        end
    end

    // link status derived options
    // status pins reach these outputs about three edges after they change
    wire early_rxdv = ctrl_one_r[`PLO_C1_EARLY_RXDV];
    wire ext_fdx    = ctrl_two_r[`PLO_C2_EXT_FDX];
    wire fdx_now    = (ext_fdx && local_s && partner_s) ? 1'b1 : pdfull_s;
    wire iso_now    = ctrl_two_r[`PLO_C2_ISOLATE] && link_s
                      && (!spd100_s || !fdx_now);

    always @(posedge REF_CLK) begin
        if (RESET) begin
            TX_DISABLE         <= 1'b0;
            FIBER_MODE         <= 1'b0;
            FAST_PD_LINKUP     <= 1'b0;
            FULL_DUPLEX        <= 1'b0;
            LED_LINK           <= 1'b0;
            MII_ISOLATE        <= 1'b0;
            RX_SAMPLE_ON_RXCLK <= 1'b0;
        end else begin
            TX_DISABLE     <= ctrl_two_r[`PLO_C2_FAR_END_DROP] && spd100_s
                              && !link_s;
            FIBER_MODE     <= ctrl_two_r[`PLO_C2_FIBER_EN];
            FAST_PD_LINKUP <= ctrl_two_r[`PLO_C2_FAST_PD];
            FULL_DUPLEX    <= fdx_now;
            MII_ISOLATE    <= iso_now;
            // activity blanks the LED in plain mode; qualified mode ignores it
            if (ctrl_two_r[`PLO_C2_LED_QUAL]) begin
                LED_LINK <= link_s && spd100_s && fdx_now;
            end else begin
                LED_LINK <= link_s && !act_s;
            end
            RX_SAMPLE_ON_RXCLK <= RMII_MODE && ctrl_two_r[`PLO_C2_RX_CLK_SEL];
        end
    end

    // receive start delimiter tracking
    reg [1:0] rx_state_r;
    reg [1:0] rx_state_nxt;
    reg       rx_dv_nxt;
    reg       rx_er_nxt;

    always @* begin
        rx_state_nxt = rx_state_r;
        rx_dv_nxt    = RX_DV & ~iso_now;
        rx_er_nxt    = 1'b0;
        if (RX_SYM_STB) begin
            case (rx_state_r)
                RX_IDLE: begin
                    if (RX_SYM_J) begin
                        rx_state_nxt = RX_GOTJ;
                        rx_dv_nxt    = early_rxdv;
                    end else if (RX_SYM_ERR && ctrl_two_r[`PLO_C2_IDLE_ERR_DET]) begin
                        rx_er_nxt = 1'b1;
                    end
                end
                RX_GOTJ: begin
                    if (RX_SYM_K) begin
                        rx_state_nxt = RX_DATA;
                        rx_dv_nxt    = 1'b1;
                    end else begin
                        rx_state_nxt = RX_IDLE;
                        rx_dv_nxt    = 1'b0;
                        rx_er_nxt    = early_rxdv;
                    end
                end
                RX_DATA: begin
                    if (RX_SYM_END) begin
                        rx_state_nxt = RX_IDLE;
                        rx_dv_nxt    = 1'b0;
                    end else begin
                        rx_er_nxt = RX_SYM_ERR;
                    end
                end
                default: begin
                    rx_state_nxt = RX_IDLE;
                    rx_dv_nxt    = 1'b0;
                end
            endcase
        end
        // isolation wins over any symbol decoded in the same cycle
        if (iso_now) begin
            rx_dv_nxt = 1'b0;
            rx_er_nxt = 1'b0;
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            rx_state_r <= RX_IDLE;
            RX_DV      <= 1'b0;
            RX_ER      <= 1'b0;
        end else begin
            rx_state_r <= rx_state_nxt;
            RX_DV      <= rx_dv_nxt;
            RX_ER      <= rx_er_nxt;
        end
    end

    // transmit path on synchronised TX_CLK rising edges
    // nibble parity restarts with every frame, so a cut frame cannot leak into the next
    reg  txclk_d_r;
    reg  nib_odd_r;
    reg  stretch_r;
    wire tx_edge = txclk_s & ~txclk_d_r;
    wire odd_det = ~ctrl_two_r[`PLO_C2_ODD_NIB_DIS];

    always @(posedge REF_CLK) begin
        if (RESET) begin
            txclk_d_r <= 1'b0;
            nib_odd_r <= 1'b0;
            stretch_r <= 1'b0;
            TX_EN_PCS <= 1'b0;
            TX_ER_PCS <= 1'b0;
        end else begin
            txclk_d_r <= txclk_s;
            if (tx_edge) begin
                if (txen_s) begin
                    nib_odd_r <= ~nib_odd_r;
                    stretch_r <= 1'b0;
                    TX_EN_PCS <= 1'b1;
                    TX_ER_PCS <= txer_s;
                end else if (TX_EN_PCS && !stretch_r && nib_odd_r && odd_det) begin
                    // frame ended on an odd nibble: one extra cycle flagged bad
                    stretch_r <= 1'b1;
                    nib_odd_r <= 1'b0;
                    TX_EN_PCS <= 1'b1;
                    TX_ER_PCS <= 1'b1;
                end else begin
                    stretch_r <= 1'b0;
                    nib_odd_r <= 1'b0;
                    TX_EN_PCS <= 1'b0;
                    TX_ER_PCS <= 1'b0;
                end
            end
        end
    end

endmodule // plo_ctrl

`default_nettype wire

// *** rtl/plo_map.vh ***
/*
 * Register map, field positions, reset values and timer figures of the
 * link option control bank.
 * Assumes a 32-bit APB slave with one word per register.
 * Printed offsets are register indices; byte address is four times the index.
 */
`ifndef PLO_MAP_VH
`define PLO_MAP_VH

// register indices as printed, and their byte addresses
`define PLO_IDX_CTRL_ONE      8'h09
`define PLO_IDX_CTRL_TWO      8'h0A
`define PLO_ADDR_CTRL_ONE     8'h24
`define PLO_ADDR_CTRL_TWO     8'h28

// reset values
`define PLO_RST_CTRL_ONE      16'h0000
`define PLO_RST_CTRL_TWO      16'h0104
`define PLO_MASK_CTRL_ONE     16'h007E

// phy_control_one fields
`define PLO_C1_FAST_MDIX      6
`define PLO_C1_ROBUST_MDIX    5
`define PLO_C1_FAST_AN_EN     4
`define PLO_C1_FAST_AN_SEL_HI 3
`define PLO_C1_FAST_AN_SEL_LO 2
`define PLO_C1_EARLY_RXDV     1

// phy_control_two fields
`define PLO_C2_FAR_END_DROP   15
`define PLO_C2_FIBER_EN       14
`define PLO_C2_FAST_PD        6
`define PLO_C2_EXT_FDX        5
`define PLO_C2_LED_QUAL       4
`define PLO_C2_ISOLATE        3
`define PLO_C2_IDLE_ERR_DET   2
`define PLO_C2_ODD_NIB_DIS    1
`define PLO_C2_RX_CLK_SEL     0

// negotiation timers in ms: break link, link fail inhibit, wait
`define PLO_AN_SEL_00         2'h0
`define PLO_AN_SEL_01         2'h1
`define PLO_AN_SEL_10         2'h2
`define PLO_T00_BREAK         8'h50
`define PLO_T00_INHIBIT       8'h32
`define PLO_T00_WAIT          8'h23
`define PLO_T01_BREAK         8'h78
`define PLO_T01_INHIBIT       8'h4B
`define PLO_T01_WAIT          8'h32
`define PLO_T10_BREAK         8'hF0
`define PLO_T10_INHIBIT       8'h96
`define PLO_T10_WAIT          8'h64

`endif

// *** sim/plo_chk.sv ***
/* port assertions for the link option bank
   assumes one clock domain, synchronous reset; bound at the foot of this file */
`timescale 1ns/10ps
`default_nettype none
module plo_chk (
    input wire logic       REF_CLK,
    input wire logic       RESET,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic       RX_SYM_STB,
    input wire logic       RX_SYM_J,
    input wire logic       RX_SYM_K,
    input wire logic       RX_DV,
    input wire logic       RX_ER,
    input wire logic       TX_EN_PCS,
    input wire logic       TX_ER_PCS,
    input wire logic       FAST_AN_ACTIVE,
    input wire logic [7:0] AN_BREAK_MS,
    input wire logic [7:0] AN_INHIBIT_MS,
    input wire logic [7:0] AN_WAIT_MS,
    input wire logic       RMII_MODE,
    input wire logic       RX_SAMPLE_ON_RXCLK
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    an_table_a: assert property (FAST_AN_ACTIVE |->
        {AN_BREAK_MS, AN_INHIBIT_MS, AN_WAIT_MS} inside {24'h50_3223, 24'h78_4B32, 24'hF0_9664})
        else $error("timer set off the table");
    an_off_a: assert property (AN_WAIT_MS == 8'h00 |->
        !FAST_AN_ACTIVE && AN_BREAK_MS == 8'h00) else $error("timers zero while active");
    dv_rise_a: assert property ($rose(RX_DV) |->
        $past(RX_SYM_STB && (RX_SYM_J || RX_SYM_K))) else $error("receive valid without delimiter");
    rx_err_a: assert property (RX_ER |-> $past(RX_SYM_STB))
        else $error("receive error without symbol");
    tx_er_a: assert property (TX_ER_PCS |-> TX_EN_PCS)
        else $error("transmit error outside enable");
    rx_clk_sel_a: assert property (RX_SAMPLE_ON_RXCLK |-> $past(RMII_MODE))
        else $error("sample clock select outside rmii");
    apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not one wait state and one cycle");
    apb_err_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule // plo_chk
bind plo_ctrl plo_chk chk (.*);
`default_nettype wire

// *** sim/plo_ctrl_bench.sv ***
/* self-checking bench of the link option bank against a register model
   assumes plo_chk bound by its own file and plo_mac as transmit partner */
`timescale 1ns/10ps
`default_nettype none
`include "plo_map.vh"
module plo_ctrl_bench;
    localparam logic [7:0] A1 = `PLO_ADDR_CTRL_ONE;
    localparam logic [7:0] A2 = `PLO_ADDR_CTRL_TWO;
    logic        REF_CLK = 1'h0, RESET = 1'h1, FIBER_STRAP = 1'h1;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RMII_MODE, LINK_UP, SPEED_100;
    logic        LOCAL_100TX, PARTNER_FORCED_100TX, PD_FULL_DUPLEX, ACTIVITY;
    logic        RX_SYM_STB, RX_SYM_J, RX_SYM_K, RX_SYM_END, RX_SYM_ERR, TX_CLK, TX_EN;
    logic        TX_ER, FAST_AN_ACTIVE, RX_DV, RX_ER, TX_EN_PCS, TX_ER_PCS, TX_DISABLE;
    logic        FIBER_MODE, FAST_PD_LINKUP, FULL_DUPLEX, LED_LINK, MII_ISOLATE;
    logic        RX_SAMPLE_ON_RXCLK, e, f;
    logic [7:0]  PADDR, AN_BREAK_MS, AN_INHIBIT_MS, AN_WAIT_MS;
    logic [31:0] PWDATA, PRDATA, r, v, seed = 32'h0000_5cf1;
    logic [15:0] c1, c2;
    logic [23:0] an_t [4] = '{24'h50_3223, 24'h78_4B32, 24'hF0_9664, 24'h00_0000};
    int          fails, checks_done, en_n, er_n, x;

    plo_ctrl uut (.*);
    plo_mac mac (.*);

    always #50 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        en_n += TX_EN_PCS;
        er_n += TX_ER_PCS;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'h1, w, a, d};
        @(posedge REF_CLK);
        PENABLE <= 1'h1;
        do @(posedge REF_CLK); while (PREADY !== 1'h1);
        r = PRDATA;
        e = PSLVERR;
        {PSEL, PENABLE} <= 2'h0;
        @(posedge REF_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'h1, a, {16'h0000, d});
        if (a == A1) c1 = d & `PLO_MASK_CTRL_ONE;
        else c2 = d;
        if (c1[6] | c1[5]) c2[6] = 1'h1;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0000_0000);
        chk("read data", r, {16'h0000, a == A1 ? c1 : c2});
    endtask
    // class bits are {J, K, END, ERR}; the idle cycle after keeps strobes apart
    task automatic sym(input logic [3:0] c);
        {RX_SYM_STB, RX_SYM_J, RX_SYM_K, RX_SYM_END, RX_SYM_ERR} <= {1'h1, c};
        @(posedge REF_CLK);
        RX_SYM_STB <= 1'h0;
        @(posedge REF_CLK);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #1_000_000;
        fails++;
        report_and_stop();
    end

    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RMII_MODE, LINK_UP, SPEED_100, LOCAL_100TX,
            PARTNER_FORCED_100TX, PD_FULL_DUPLEX, ACTIVITY, RX_SYM_STB, RX_SYM_J, RX_SYM_K,
            RX_SYM_END, RX_SYM_ERR} = '0;
        repeat (10) @(posedge REF_CLK);
        RESET <= 1'h0;
        repeat (2) @(posedge REF_CLK);
        c1 = 16'h0000;
        c2 = 16'h4104;
        rd(A1);
        rd(A2);
        apb(1'h0, 8'h2C, 32'h0000_0000);
        chk("unmapped error", e, 1'h1);
        chk("unmapped data", r, 32'h0000_0000);
        repeat (4) begin
            v = rnd();
            wr(A1, v[15:0]);
            rd(A1);
            rd(A2);
        end
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr(A1, {11'h000, 1'h1, s[1:0], 2'h0});
            repeat (2) @(posedge REF_CLK);
            chk("an active", FAST_AN_ACTIVE, s != 3);
            chk("an timers", {AN_BREAK_MS, AN_INHIBIT_MS, AN_WAIT_MS}, an_t[s]);
        end
        $display("test negotiation timers done");
        repeat (24) begin
            v = rnd();
            wr(A2, v[15:0]);
            {LINK_UP, SPEED_100, LOCAL_100TX, PARTNER_FORCED_100TX, PD_FULL_DUPLEX, ACTIVITY,
                RMII_MODE} <= v[22:16];
            repeat (6) @(posedge REF_CLK);
            rd(A2);
            f = c2[5] & LOCAL_100TX & PARTNER_FORCED_100TX | PD_FULL_DUPLEX;
            chk("full duplex", FULL_DUPLEX, f);
            chk("led", LED_LINK, c2[4] ? LINK_UP & SPEED_100 & f : LINK_UP & !ACTIVITY);
            chk("isolate", MII_ISOLATE, c2[3] & LINK_UP & (!SPEED_100 | !f));
            chk("tx disable", TX_DISABLE, c2[15] & SPEED_100 & !LINK_UP);
            chk("fiber", FIBER_MODE, c2[14]);
            chk("fast pd", FAST_PD_LINKUP, c2[6]);
            chk("rx clock select", RX_SAMPLE_ON_RXCLK, RMII_MODE & c2[0]);
        end
        $display("test status outputs done");
        LINK_UP <= 1'h0;
        repeat (6) @(posedge REF_CLK);
        for (int m = 0; m < 2; m++) begin
            wr(A1, {14'h0000, m[0], 1'h0});
            sym(4'h8);
            chk("rx dv after j", RX_DV, m[0]);
            sym(m ? 4'h0 : 4'h4);
            chk("rx dv second", RX_DV, !m[0]);
            chk("rx er second", RX_ER, m[0]);
            sym(4'h2);
            chk("rx dv end", RX_DV, 1'h0);
        end
        for (int b = 0; b < 2; b++) begin
            wr(A2, c2 & 16'hFFFB | {13'h0000, b[0], 2'h0});
            sym(4'h1);
            chk("rx er idle", RX_ER, b[0]);
        end
        $display("test receive done");
        for (int k = 0; k < 4; k++) begin
            wr(A2, c2 & 16'hFFFD | {14'h0000, k[1], 1'h0});
            en_n = 0;
            er_n = 0;
            mac.send(3 + k[0]);
            repeat (10) @(posedge REF_CLK);
            x = !k[0] && !k[1];
            chk("tx en cycles", en_n, (3 + k[0] + x) * 8);
            chk("tx er cycles", er_n, (x + k[0]) * 8);
        end
        $display("test transmit done");
        report_and_stop();
    end
endmodule // plo_ctrl_bench
`default_nettype wire

// *** sim/plo_mac.sv ***
/* transmit side of the MAC partner: frames of nibbles on TX_CLK
   assumes the bench calls send from just after a REF_CLK edge */
`timescale 1ns/10ps
`default_nettype none
module plo_mac (
    output var logic TX_CLK,
    output var logic TX_EN,
    output var logic TX_ER
);
    initial begin
        TX_CLK = 1'h0;
        TX_EN = 1'h0;
        TX_ER = 1'h0;
    end
    // clock stands still between frames; odd offset keeps its edges off REF_CLK rising edges
    task automatic send(input int n);
        #37;
        for (int i = 0; i < n + 3; i++) begin
            #400 TX_CLK = 1'h1;
            TX_EN <= (i < n);
            TX_ER <= (i == 1) && (n == 4);
            #400 TX_CLK = 1'h0;
        end
    endtask
endmodule // plo_mac
`default_nettype wire
